// ===== rtl/clock_reset_generation.sv
// Clock and reset generator: PLL control, reset sequencing, clock dividers
`timescale 1ns/1ns
module clock_reset_generation
  import crg_pkg::*;
#(
  parameter int unsigned RELEASE_LEN = RELEASE_CYCLES,
  parameter int unsigned POR_LEN     = POR_CYCLES,
  parameter bit          HI_VARIANT  = 1'b0,
  parameter int unsigned DIV_D0      = DIV_DSP,
  parameter int unsigned DIV_D1      = DIV_SPDIF,
  parameter int unsigned DIV_D2      = DIV_ADC,
  parameter int unsigned DIV_D3      = DIV_MCLK
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                crystal_ref_in,
  output logic                     buffered_ref_out,
  input  wire logic                ext_reset_in_n,
  input  wire crg_pkg::crg_supply_s supply_ok,
  input  wire logic [3:0]          boot_sel_pins,
  input  wire logic                pll_lock,
  input  wire logic                fw_pll_enable,
  input  wire logic                fw_select_pll,
  input  wire logic                fw_mult_load,
  input  wire logic [3:0]          fw_mult,
  output crg_pkg::crg_pll_ctrl_s   pll_ctrl,
  output logic                     mult_reject,
  output logic                     pwm_on_pll,
  output crg_pkg::crg_dclk_s       dclk,
  output logic                     sys_reset_out_n,
  output logic                     int_reset_n,
  output logic [3:0]               boot_mode,
  output logic                     boot_start
);
  import crg_pkg::*;

  localparam int unsigned CW = $clog2(RELEASE_LEN + 1) + 1;
  localparam int unsigned PW = $clog2(POR_LEN + 1) + 1;
  localparam int unsigned DSP_MAX_KHZ =
    HI_VARIANT ? DSP_MAX_HI_KHZ : DSP_MAX_LO_KHZ;

  typedef struct packed {
    logic [1:0]               ext_sync;
    logic [1:0]               lock_sync;
    logic [1:0]               pll_ok_sync;
    logic [1:0]               core_ok_sync;
    logic [1:0]               pwm_ok_sync;
    logic [1:0][3:0]          boot_sync;
    logic                     pll_ok_prev;
    logic                     ext_prev;
    logic [PW-1:0]            por_cnt;
    logic                     por_active;
    logic [CW-1:0]            rel_cnt;
    logic                     int_rst_n;
    logic [3:0]               boot_mode;
    logic                     boot_start;
    logic                     rst_out_n;
    crg_sw_e                  sw;
    logic [1:0]               gap_cnt;
    crg_pll_ctrl_s            pll;
    logic                     mult_reject;
  } crg_state_s;

  crg_state_s state;
  crg_state_s next_state;
  logic       div_dsp;
  logic       div_spdif;
  logic       div_adc;
  logic       div_mclk;

  function automatic logic mult_ok(input logic [3:0] m);
    logic range_ok;
    logic rate_ok;
    range_ok = (m >= MULT_MIN) && (m <= MULT_MAX);
    rate_ok  = (REF_KHZ * 32'(m)) <= DSP_MAX_KHZ;
    return range_ok && rate_ok;
  endfunction : mult_ok

  // Analog buffer of the reference for chained devices
  assign buffered_ref_out = crystal_ref_in;

  always_comb begin
    logic sys_rst;
    logic lock_ok;
    sys_rst = 1'b0;
    lock_ok = 1'b0;
    next_state = state;

    // Two-flop synchronisers
    next_state.ext_sync     = {state.ext_sync[0], ext_reset_in_n};
    next_state.lock_sync    = {state.lock_sync[0], pll_lock};
    next_state.pll_ok_sync  = {state.pll_ok_sync[0], supply_ok.pll_ok};
    next_state.core_ok_sync = {state.core_ok_sync[0], supply_ok.core_ok};
    next_state.pwm_ok_sync  = {state.pwm_ok_sync[0], supply_ok.pwm_ok};
    next_state.boot_sync    = {state.boot_sync[0], boot_sel_pins};
    next_state.pll_ok_prev  = state.pll_ok_sync[1];
    next_state.ext_prev     = state.ext_sync[1];
    lock_ok = state.lock_sync[1];

    // Power-on pulse on each rise of the PLL supply
    if (state.pll_ok_sync[1] && !state.pll_ok_prev) begin
      next_state.por_active = 1'b1;
      next_state.por_cnt    = '0;
    end else if (state.por_active) begin
      if (state.por_cnt == PW'(POR_LEN - 1)) begin
        next_state.por_active = 1'b0;
      end else begin
        next_state.por_cnt = state.por_cnt + PW'(1);
      end
    end

    // Reset output pin
    next_state.rst_out_n = !next_state.por_active
                         && state.core_ok_sync[1]
                         && state.pwm_ok_sync[1];

    // System reset and release counter
    sys_rst = !state.ext_sync[1] || state.por_active;
    next_state.boot_start = 1'b0;
    if (sys_rst) begin
      next_state.rel_cnt   = '0;
      next_state.int_rst_n = 1'b0;
    end else if (!state.int_rst_n) begin
      if (state.rel_cnt == CW'(RELEASE_LEN - 1)) begin
        next_state.int_rst_n  = 1'b1;
        next_state.boot_start = 1'b1;
      end else begin
        next_state.rel_cnt = state.rel_cnt + CW'(1);
      end
    end

    // Boot mode capture on external reset release
    if (state.ext_sync[1] && !state.ext_prev) begin
      next_state.boot_mode = state.boot_sync[1];
    end

    // Multiplier load, firmware only
    next_state.mult_reject = 1'b0;
    if (fw_mult_load && state.int_rst_n) begin
      if (mult_ok(fw_mult)) begin
        next_state.pll.mult = fw_mult;
      end else begin
        next_state.mult_reject = 1'b1;
      end
    end

    // Bypass and glitch-free clock switch
    next_state.pll.enable = fw_pll_enable;
    case (state.sw)
      ST_BYPASS: begin
        next_state.pll.sel_pll  = 1'b0;
        next_state.pll.gate_ref = 1'b1;
        next_state.pll.gate_pll = 1'b0;
        if (fw_pll_enable && fw_select_pll) begin
          next_state.sw = ST_WAIT_LOCK;
        end
      end
      ST_WAIT_LOCK: begin
        if (!fw_pll_enable || !fw_select_pll) begin
          next_state.sw = ST_BYPASS;
        end else if (lock_ok) begin
          next_state.pll.gate_ref = 1'b0;
          next_state.gap_cnt      = '0;
          next_state.sw           = ST_GAP_TO_PLL;
        end
      end
      ST_GAP_TO_PLL: begin
        if (state.gap_cnt == 2'(SWITCH_GAP - 1)) begin
          next_state.pll.sel_pll  = 1'b1;
          next_state.pll.gate_pll = 1'b1;
          next_state.sw           = ST_PLL;
        end else begin
          next_state.gap_cnt = state.gap_cnt + 2'h1;
        end
      end
      ST_PLL: begin
        if (!fw_pll_enable || !fw_select_pll) begin
          next_state.pll.gate_pll = 1'b0;
          next_state.gap_cnt      = '0;
          next_state.sw           = ST_GAP_TO_REF;
        end
      end
      ST_GAP_TO_REF: begin
        if (state.gap_cnt == 2'(SWITCH_GAP - 1)) begin
          next_state.pll.sel_pll  = 1'b0;
          next_state.pll.gate_ref = 1'b1;
          next_state.sw           = ST_BYPASS;
        end else begin
          next_state.gap_cnt = state.gap_cnt + 2'h1;
        end
      end
      default: begin
        next_state.sw = ST_BYPASS;
      end
    endcase

    // Reset holds PLL off and on bypass
    if (sys_rst) begin
      next_state.pll.enable   = 1'b0;
      next_state.pll.sel_pll  = 1'b0;
      next_state.pll.gate_ref = 1'b1;
      next_state.pll.gate_pll = 1'b0;
      next_state.pll.mult     = MULT_RST;
      next_state.sw           = ST_BYPASS;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state           <= '0;
      state.sw        <= ST_BYPASS;
      state.pll.mult  <= MULT_RST;
      state.pll.gate_ref <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // Derived clocks, each from its own divider
  crg_clk_div #(
    .DIV     (DIV_D0)
  ) div_dsp_u (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .run     (state.int_rst_n),
    .clk_out (div_dsp)
  );

  crg_clk_div #(
    .DIV     (DIV_D1)
  ) div_spdif_u (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .run     (state.int_rst_n),
    .clk_out (div_spdif)
  );

  crg_clk_div #(
    .DIV     (DIV_D2)
  ) div_adc_u (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .run     (state.int_rst_n),
    .clk_out (div_adc)
  );

  crg_clk_div #(
    .DIV     (DIV_D3)
  ) div_mclk_u (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .run     (state.int_rst_n),
    .clk_out (div_mclk)
  );

  assign pll_ctrl        = state.pll;
  assign mult_reject     = state.mult_reject;
  assign pwm_on_pll      = state.pll.sel_pll;
  assign dclk            = {div_dsp, div_spdif, div_adc, div_mclk};
  assign sys_reset_out_n = state.rst_out_n;
  assign int_reset_n     = state.int_rst_n;
  assign boot_mode       = state.boot_mode;
  assign boot_start      = state.boot_start;
endmodule : clock_reset_generation

// Divider: toggles its output every DIV cycles while running
module crg_clk_div
  import crg_pkg::*;
#(
  parameter int unsigned DIV = 1,
  parameter int unsigned W   = DCLK_W
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      clk_out
);
  import crg_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         clk;
  } crg_div_s;

  crg_div_s state;
  crg_div_s next_state;

  always_comb begin
    next_state = state;
    if (!run) begin
      next_state.cnt = '0;
      next_state.clk = 1'b0;
    end else if (state.cnt == W'(DIV - 1)) begin
      next_state.cnt = '0;
      next_state.clk = !state.clk;
    end else begin
      next_state.cnt = state.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign clk_out = state.clk;
endmodule : crg_clk_div

// ===== rtl/crg_pkg.sv
// Package: constants and carrier types of the clock and reset generator
package crg_pkg;
  // Multiplier range and start value
  localparam logic [3:0] MULT_MIN      = 4'h4;
  localparam logic [3:0] MULT_MAX      = 4'hf;
  localparam logic [3:0] MULT_RST      = 4'h4;
  // Clock rate and derived timing
  localparam int unsigned CLK_KHZ        = 20000;
  localparam int unsigned RELEASE_TIME_NS = 10000;
  localparam int unsigned RELEASE_CYC_MIN = 64;
  localparam int unsigned RELEASE_CYC_T   =
    (RELEASE_TIME_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int unsigned RELEASE_CYCLES  =
    (RELEASE_CYC_T > RELEASE_CYC_MIN) ? RELEASE_CYC_T : RELEASE_CYC_MIN;
  localparam int unsigned POR_TIME_NS    = 1000;
  localparam int unsigned POR_CYCLES     =
    (POR_TIME_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int unsigned SWITCH_GAP     = 2;
  // Reference and variant ceilings in kHz
  localparam int unsigned REF_KHZ        = 24576;
  localparam int unsigned DSP_MAX_LO_KHZ = 147456;
  localparam int unsigned DSP_MAX_HI_KHZ = 159744;
  // Default divider ratios of derived clocks
  localparam int unsigned DIV_DSP        = 1;
  localparam int unsigned DIV_SPDIF      = 4;
  localparam int unsigned DIV_ADC        = 8;
  localparam int unsigned DIV_MCLK       = 2;
  localparam int unsigned NUM_DCLK       = 4;
  localparam int unsigned DCLK_W         = 8;

  typedef struct packed {
    logic pll_ok;
    logic core_ok;
    logic pwm_ok;
  } crg_supply_s;

  typedef struct packed {
    logic       enable;
    logic       sel_pll;
    logic       gate_ref;
    logic       gate_pll;
    logic [3:0] mult;
  } crg_pll_ctrl_s;

  typedef struct packed {
    logic dsp;
    logic spdif;
    logic adc;
    logic mclk;
  } crg_dclk_s;

  typedef enum logic [2:0] {
    ST_BYPASS,
    ST_WAIT_LOCK,
    ST_GAP_TO_PLL,
    ST_PLL,
    ST_GAP_TO_REF
  } crg_sw_e;
endpackage : crg_pkg

// ===== dv/crg_properties.sv
// Checker: port-level properties of the clock and reset generator
`timescale 1ns/1ns
module crg_props
  import crg_pkg::*;
(
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  input wire logic                  ext_reset_in_n,
  input wire crg_pkg::crg_supply_s   supply_ok,
  input wire logic                  pll_lock,
  input wire logic                  fw_select_pll,
  input wire logic                  fw_mult_load,
  input wire logic [3:0]            fw_mult,
  input wire crg_pkg::crg_pll_ctrl_s pll_ctrl,
  input wire logic                  mult_reject,
  input wire crg_pkg::crg_dclk_s     dclk,
  input wire logic                  sys_reset_out_n,
  input wire logic                  int_reset_n,
  input wire logic                  boot_start
);
  wire ok_m = fw_mult >= MULT_MIN && REF_KHZ * fw_mult <= DSP_MAX_LO_KHZ;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_mult_load: assert property (
    fw_mult_load && int_reset_n && ok_m |=> pll_ctrl.mult == $past(fw_mult))
    else $error("multiplier not loaded");
  a_mult_refuse: assert property (
    fw_mult_load && int_reset_n && !ok_m |=>
      mult_reject && $stable(pll_ctrl.mult))
    else $error("illegal multiplier taken");
  a_mult_range: assert property (
    pll_ctrl.mult >= MULT_MIN && REF_KHZ * pll_ctrl.mult <= DSP_MAX_LO_KHZ)
    else $error("multiplier out of range");
  a_lock_gate: assert property (
    $rose(pll_ctrl.sel_pll) |-> $past(pll_lock, 3) && fw_select_pll)
    else $error("switch without lock or request");
  a_switch_gap: assert property (
    $fell(pll_ctrl.gate_ref) |-> !pll_ctrl.gate_pll [*2] ##1 pll_ctrl.gate_pll)
    else $error("switch gap wrong");
  a_ext_reset: assert property (
    !ext_reset_in_n [*3] |=> !int_reset_n && !pll_ctrl.enable
      && pll_ctrl.mult == MULT_RST)
    else $error("reset state not held");
  a_brown_out: assert property (
    (!(supply_ok.core_ok && supply_ok.pwm_ok)) [*3] |=> !sys_reset_out_n)
    else $error("brown-out not on reset output");
  a_div_spdif: assert property (
    disable iff (!rst_n || !int_reset_n)
    $changed(dclk.spdif) |=>
      $stable(dclk.spdif) [*3] ##1 $changed(dclk.spdif))
    else $error("spdif clock divide wrong");
  a_boot_pulse: assert property (
    boot_start |-> int_reset_n ##1 !boot_start)
    else $error("boot start pulse wrong");
endmodule : crg_props
bind clock_reset_generation crg_props chk_u (.clk_sys, .rst_n,
  .ext_reset_in_n, .supply_ok, .pll_lock, .fw_select_pll, .fw_mult_load,
  .fw_mult, .pll_ctrl, .mult_reject, .dclk, .sys_reset_out_n, .int_reset_n,
  .boot_start);

// ===== dv/crg_board.sv
// Board model: reset pin, supply rails, PLL lock and shared reference
`timescale 1ns/1ns
module crg_board
  import crg_pkg::*;
(
  input wire logic                clk_sys,
  input wire logic                hold_reset,
  input wire logic [2:0]          rails,
  input wire logic [7:0]          lock_dly,
  input wire logic                pll_en,
  output logic                    ext_reset_in_n,
  output crg_pkg::crg_supply_s     supply_ok,
  output logic                    pll_lock,
  output logic                    crystal_ref_in
);
  logic [7:0] cnt;
  initial begin
    cnt = 8'h00;
    ext_reset_in_n = 1'b0;
    supply_ok = '0;
    pll_lock = 1'b0;
    crystal_ref_in = 1'b0;
  end
  always @(posedge clk_sys) begin
    ext_reset_in_n <= !hold_reset;
    supply_ok <= rails;
    crystal_ref_in <= !crystal_ref_in;
    cnt <= !pll_en ? 8'h00 : (cnt == 8'hff) ? cnt : cnt + 8'h01;
    pll_lock <= pll_en && cnt >= lock_dly;
  end
endmodule : crg_board

// ===== dv/clock_reset_generation_bench.sv
// Testbench: board, firmware stimulus and a multiplier model
`timescale 1ns/1ns
module clock_reset_generation_bench;
  import crg_pkg::*;
  localparam int REL_LEN = 4;
  logic          clk_sys, rst_n, hold_reset, fw_pll_enable, fw_select_pll;
  logic          fw_mult_load, ext_reset_in_n, pll_lock, crystal_ref_in;
  logic          buffered_ref_out, mult_reject, pwm_on_pll, sys_reset_out_n;
  logic          int_reset_n, boot_start;
  logic [2:0]    rails;
  logic [3:0]    boot_sel_pins, fw_mult, boot_mode;
  logic [7:0]    lock_dly;
  crg_supply_s   supply_ok;
  crg_pll_ctrl_s pll_ctrl;
  crg_dclk_s     dclk;
  int            bad_count, n_compared, seed, exp_mult, i;
  clock_reset_generation #(.RELEASE_LEN(REL_LEN), .POR_LEN(3)) dut_u (
    .clk_sys, .rst_n, .crystal_ref_in, .buffered_ref_out, .ext_reset_in_n,
    .supply_ok, .boot_sel_pins, .pll_lock, .fw_pll_enable, .fw_select_pll,
    .fw_mult_load, .fw_mult, .pll_ctrl, .mult_reject, .pwm_on_pll, .dclk,
    .sys_reset_out_n, .int_reset_n, .boot_mode, .boot_start);
  crg_board board_u (.clk_sys, .hold_reset, .rails, .lock_dly,
    .pll_en(pll_ctrl.enable), .ext_reset_in_n, .supply_ok, .pll_lock,
    .crystal_ref_in);
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [3:0] e, logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic sig(input int k);
    sig = k == 0 ? int_reset_n : k == 1 ? pwm_on_pll : sys_reset_out_n;
  endfunction : sig
  task automatic wait_for(input int k, input logic v);
    for (int n = 0; n < 400 && sig(k) !== v; n++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("wait", {3'h0, v}, {3'h0, sig(k)});
    if (sig(k) !== v) results();
  endtask : wait_for
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic load(input logic [3:0] v);
    logic ok;
    ok = v >= MULT_MIN && REF_KHZ * v <= DSP_MAX_LO_KHZ;
    @(posedge clk_sys);
    fw_mult_load <= 1'b1;
    fw_mult <= v;
    @(posedge clk_sys);
    fw_mult_load <= 1'b0;
    #1;
    if (ok) exp_mult = v;
    chk("mult", exp_mult[3:0], pll_ctrl.mult);
    chk("reject", {3'h0, !ok}, {3'h0, mult_reject});
  endtask : load
  task automatic clk_chk();
    logic [3:0] prev, cur;
    int         tog [4];
    int         divs [4];
    divs = '{DIV_MCLK, DIV_ADC, DIV_SPDIF, DIV_DSP};
    tog  = '{0, 0, 0, 0};
    prev = dclk;
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      cur = dclk;
      for (int k = 0; k < 4; k++)
        if (cur[k] !== prev[k]) tog[k]++;
      prev = cur;
    end
    for (int k = 0; k < 4; k++)
      chk("dclk", 4'(8 / divs[k]), 4'(tog[k]));
  endtask : clk_chk
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    seed = 32'he124;
    bad_count = 0;
    n_compared = 0;
    exp_mult = MULT_RST;
    {rst_n, hold_reset, rails, lock_dly} = {2'b01, 3'h0, 8'h00};
    {fw_pll_enable, fw_select_pll, fw_mult_load, fw_mult} = 7'h00;
    boot_sel_pins = 4'($random(seed));
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rails <= 3'h7;
    repeat (8) @(posedge clk_sys);
    hold_reset <= 1'b0;
    wait_for(0, 1'b1);
    chk("start", 4'h1, {3'h0, boot_start});
    chk("boot", boot_sel_pins, boot_mode);
    chk("rstout", 4'h1, {3'h0, sys_reset_out_n});
    chk("bypass", 4'h0, {3'h0, pwm_on_pll});
    clk_chk();
    for (i = 0; i < 24; i++) load(i < 16 ? 4'(i) : 4'($random(seed)));
    for (i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      lock_dly <= i ? 8'h28 : 8'h00;
      fw_pll_enable <= 1'b1;
      fw_select_pll <= 1'b1;
      step(20);
      if (i) chk("nolock", 4'h0, {3'h0, pwm_on_pll});
      wait_for(1, 1'b1);
      chk("gates", 4'h1, {2'h0, pll_ctrl.gate_ref, pll_ctrl.gate_pll});
      chk("on", 4'h1, {3'h0, pll_ctrl.enable});
      @(posedge clk_sys);
      fw_select_pll <= 1'b0;
      fw_pll_enable <= 1'(i);
      wait_for(1, 1'b0);
      chk("gates", 4'h2, {2'h0, pll_ctrl.gate_ref, pll_ctrl.gate_pll});
    end
    for (i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      rails <= 3'h7 ^ (3'h1 << i);
      step(5);
      if (i < 2) chk("brown", 4'h0, {3'h0, sys_reset_out_n});
      @(posedge clk_sys);
      rails <= 3'h7;
      wait_for(2, 1'b0);
      wait_for(2, 1'b1);
    end
    exp_mult = MULT_RST;
    wait_for(0, 1'b1);
    chk("por mult", exp_mult[3:0], pll_ctrl.mult);
    load(4'h5);
    @(posedge clk_sys);
    hold_reset <= 1'b1;
    boot_sel_pins <= ~boot_sel_pins;
    step(6);
    chk("ext", 4'h0, {3'h0, int_reset_n});
    chk("ext mult", 4'h4, pll_ctrl.mult);
    @(posedge clk_sys);
    hold_reset <= 1'b0;
    step(REL_LEN + 2);
    chk("hold", 4'h0, {3'h0, int_reset_n});
    step(1);
    chk("release", 4'h1, {3'h0, int_reset_n});
    chk("start", 4'h1, {3'h0, boot_start});
    wait_for(0, 1'b1);
    chk("boot", boot_sel_pins, boot_mode);
    chk("ref", {3'h0, crystal_ref_in}, {3'h0, buffered_ref_out});
    clk_chk();
    results();
  end
endmodule : clock_reset_generation_bench
